// ===== core/afr_pkg.sv
// package: register map, fields and constants of the converter control block
// assumes: 16-bit register port, byte-addressed offsets below
package afr_pkg;
    // register offsets (byte addresses, all multiples of four)
    localparam logic [31:0] REFERENCE_CONTROL_ADDR   = 32'h4000_8808;
    localparam logic [31:0] BUFFER_POWERDOWN_ADDR    = 32'h4000_8824;
    localparam logic [31:0] FILTER_CONFIG_ADDR       = 32'h4000_8840;
    localparam logic [31:0] PRIMARY_CONTROL_ADDR     = 32'h4000_8844;
    localparam logic [31:0] MODE_REG_ADDR            = 32'h4000_8848;
    localparam logic [31:0] FAST_TEMP_ADDR           = 32'h4000_884C;
    localparam logic [31:0] VOLTAGE_RESULT_ADDR      = 32'h4000_8850;
    localparam logic [31:0] THRESHOLD_ADDR           = 32'h4000_8854;
    localparam logic [31:0] COMPARE_CONFIG_ADDR      = 32'h4000_8858;
    localparam logic [31:0] COUNT_PRESET_ADDR        = 32'h4000_885C;
    localparam logic [31:0] ACCUM_LO_ADDR            = 32'h4000_8860;
    localparam logic [31:0] ACCUM_HI_ADDR            = 32'h4000_8864;
    localparam logic [31:0] STATUS_ADDR              = 32'h4000_8868;
    // reset values
    localparam logic [15:0] REFERENCE_CONTROL_RST = 16'h0002;
    localparam logic [15:0] BUFFER_POWERDOWN_RST  = 16'h0001;
    localparam logic [15:0] FILTER_CONFIG_RST     = 16'h0007;
    localparam logic [15:0] PRIMARY_CONTROL_RST   = 16'h0000;
    // field positions, sinc4 decimation limit and settle count
    localparam int OWNER_SEL_BIT     = 1;
    localparam int REF_PD_BIT        = 0;
    localparam int BUF_PD_BIT        = 0;
    localparam int SINC4_BIT         = 14;
    localparam int DIAG_POS_BIT      = 12;
    localparam int DIAG_NEG_BIT      = 13;
    localparam int SCALE_LO_BIT      = 10;
    localparam int SCALE_HI_BIT      = 11;
    localparam int CMP_EN_BIT        = 0;
    localparam int CNT_EN_BIT        = 1;
    localparam logic [6:0] DECIM_SINC4_MAX = 7'h0E;
    localparam logic [1:0] SETTLE_CYCLES   = 2'h3;
    // fast-temperature sequencer states, gray along the usual path except the AFR_HOLD2 to AFR_VOLT step
    typedef enum logic [2:0] {
        AFR_VOLT   = 3'b000,
        AFR_ARMED  = 3'b001,
        AFR_TEMP   = 3'b011,
        AFR_HOLD1  = 3'b010,
        AFR_HOLD2  = 3'b110
    } afr_seq_e;
endpackage

// ===== core/afr_acc_if.sv
// interface: accumulator add request and running sum
// assumes: single clock domain
`timescale 1ns/10ps
interface afr_acc_if;
    logic        add;
    logic        clr;
    logic [19:0] value;
    logic [31:0] sum;
    modport ctl (output add, output clr, output value, input sum);
    modport acc (input add, input clr, input value, output sum);
endinterface

// ===== core/afr_accum.sv
// module: 32-bit accumulator of signed primary results
// assumes: synchronous active-high reset, one add per strobe
`timescale 1ns/10ps
module afr_accum (
    input  wire logic i_core_clk,
    input  wire logic i_sys_rst,
    afr_acc_if.acc    acc
);
    logic [31:0] sum_r;
    logic [31:0] sum_nxt;

    always_comb begin
        sum_nxt = sum_r;
        if (acc.clr) begin
            sum_nxt = 32'h0000_0000;
        end else if (acc.add) begin
            sum_nxt = sum_r + {{12{acc.value[19]}}, acc.value};
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            sum_r <= 32'h0000_0000;
        end else begin
            sum_r <= sum_nxt;
        end
    end

    assign acc.sum = sum_r;
endmodule

// ===== core/afr_top.sv
// module: converter control (filter clamp, fast temp, reference, compare)
// assumes: register port with read data one cycle later; modulator
// conversion-done strobes are one cycle, synchronous to i_core_clk
//
// How it works
// - sinc4 mode forces averaging factor to zero
// - sinc4 mode clamps decimation factor to 0x0E
// - default channel switch settles after three conversions
// - fast temperature request acts one conversion later
// - temperature flag needs prior voltage result read
// - temp at fourth conversion, voltage resumes seventh
// - bits 13:12 switch the two diagnostic sources
// - owner select bit gives reference to converter/user
// - user-mode power-down bit gates internal reference
// - buffer bit powers buffer down, routes external
// - scaling field 11:10 picks 14/16 and 13/16
// - result magnitude above threshold raises interrupt
// - threshold counter reaching preset raises interrupt
// - primary results summed in 32-bit accumulator
// - decimation bits 6:0, averaging bits 13:8
//
// Our own choice: the plain strobed port.
`timescale 1ns/10ps
module afr_top (
    input  wire logic        i_core_clk,
    input  wire logic        i_sys_rst,
    input  wire logic [31:0] i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic        i_cur_done,
    input  wire logic [19:0] i_cur_data,
    input  wire logic        i_volt_done,
    input  wire logic [19:0] i_volt_data,
    input  wire logic        i_adc_ref_req,
    output logic      [15:0] o_rdata,
    output logic      [6:0]  o_decim_factor,
    output logic      [5:0]  o_avg_factor,
    output logic             o_temp_select,
    output logic             o_diag_pos_en,
    output logic             o_diag_neg_en,
    output logic             o_scale_14_en,
    output logic             o_scale_13_en,
    output logic             o_ref_en,
    output logic             o_buf_en,
    output logic             o_ext_ref_sel,
    output logic             o_irq
);
    logic [15:0] refctl_r, refctl_nxt;
    logic [15:0] bufpd_r, bufpd_nxt;
    logic [15:0] flt_r, flt_nxt;
    logic [15:0] pctl_r, pctl_nxt;
    logic [15:0] mode_r, mode_nxt;
    logic        fast_r, fast_nxt;
    logic [19:0] vres_r, vres_nxt;
    logic [19:0] thr_r, thr_nxt;
    logic [15:0] ccfg_r, ccfg_nxt;
    logic [15:0] preset_r, preset_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic        vread_r, vread_nxt;
    logic        tvalid_r, tvalid_nxt;
    logic        vvalid_r, vvalid_nxt;
    logic        first_r, first_nxt;
    logic        chsw_r, chsw_nxt;
    logic [1:0]  settle_r, settle_nxt;
    logic        cmp_hit_r, cmp_hit_nxt;
    logic        cnt_hit_r, cnt_hit_nxt;
    logic [15:0] rdata_nxt;
    logic        temp_sel_nxt;
    logic        irq_nxt;
    logic [19:0] mag;
    logic [6:0]  decim_eff;
    logic [5:0]  avg_eff;
    logic        sinc4;
    logic        cfg_wr;
    afr_pkg::afr_seq_e seq_r, seq_nxt;

    afr_acc_if acc_bus ();

    afr_accum u_accum (
        .i_core_clk (i_core_clk),
        .i_sys_rst  (i_sys_rst),
        .acc        (acc_bus.acc)
    );

    assign acc_bus.add   = i_cur_done;
    assign acc_bus.clr   = i_wr && (i_addr == afr_pkg::ACCUM_LO_ADDR);
    assign acc_bus.value = i_cur_data;

    // effective filter settings
    always_comb begin
        sinc4     = flt_r[afr_pkg::SINC4_BIT];
        decim_eff = flt_r[6:0];
        avg_eff   = flt_r[13:8];
        if (sinc4) begin
            avg_eff = 6'h00;
            if (flt_r[6:0] > afr_pkg::DECIM_SINC4_MAX) begin
                decim_eff = afr_pkg::DECIM_SINC4_MAX;
            end
        end
        mag = i_cur_data[19] ? 20'(-i_cur_data) : i_cur_data;
        cfg_wr = i_wr && (i_addr == afr_pkg::FILTER_CONFIG_ADDR
                       || i_addr == afr_pkg::PRIMARY_CONTROL_ADDR
                       || i_addr == afr_pkg::MODE_REG_ADDR);
    end

    // register writes and reads
    always_comb begin
        refctl_nxt = refctl_r;
        bufpd_nxt  = bufpd_r;
        flt_nxt    = flt_r;
        pctl_nxt   = pctl_r;
        mode_nxt   = mode_r;
        fast_nxt   = fast_r;
        thr_nxt    = thr_r;
        ccfg_nxt   = ccfg_r;
        preset_nxt = preset_r;
        rdata_nxt  = 16'h0000;
        if (i_wr) begin
            unique case (i_addr)
                afr_pkg::REFERENCE_CONTROL_ADDR: refctl_nxt = {14'h0000,
                                                  i_wdata[1:0]};
                afr_pkg::BUFFER_POWERDOWN_ADDR:  bufpd_nxt = {15'h0000,
                                                  i_wdata[0]};
                afr_pkg::FILTER_CONFIG_ADDR:     flt_nxt = i_wdata;
                afr_pkg::PRIMARY_CONTROL_ADDR:   pctl_nxt = i_wdata;
                afr_pkg::MODE_REG_ADDR:          mode_nxt = i_wdata;
                afr_pkg::FAST_TEMP_ADDR:         fast_nxt = i_wdata[0];
                afr_pkg::THRESHOLD_ADDR:         thr_nxt = {4'h0, i_wdata};
                afr_pkg::COMPARE_CONFIG_ADDR:    ccfg_nxt = i_wdata;
                afr_pkg::COUNT_PRESET_ADDR:      preset_nxt = i_wdata;
                default: ;
            endcase
        end
        if (i_rd) begin
            unique case (i_addr)
                afr_pkg::REFERENCE_CONTROL_ADDR: rdata_nxt = refctl_r;
                afr_pkg::BUFFER_POWERDOWN_ADDR:  rdata_nxt = bufpd_r;
                afr_pkg::FILTER_CONFIG_ADDR:     rdata_nxt = flt_r;
                afr_pkg::PRIMARY_CONTROL_ADDR:   rdata_nxt = pctl_r;
                afr_pkg::MODE_REG_ADDR:          rdata_nxt = mode_r;
                afr_pkg::FAST_TEMP_ADDR:         rdata_nxt = {15'h0000,
                                                  fast_r};
                afr_pkg::VOLTAGE_RESULT_ADDR:    rdata_nxt = vres_r[19:4];
                afr_pkg::THRESHOLD_ADDR:         rdata_nxt = thr_r[15:0];
                afr_pkg::COMPARE_CONFIG_ADDR:    rdata_nxt = ccfg_r;
                afr_pkg::COUNT_PRESET_ADDR:      rdata_nxt = preset_r;
                afr_pkg::ACCUM_LO_ADDR:          rdata_nxt =
                                                  acc_bus.sum[15:0];
                afr_pkg::ACCUM_HI_ADDR:          rdata_nxt =
                                                  acc_bus.sum[31:16];
                afr_pkg::STATUS_ADDR:            rdata_nxt = {9'h000,
                                                  cnt_hit_r, cmp_hit_r,
                                                  settle_r, first_r,
                                                  tvalid_r, vvalid_r};
                default: ;
            endcase
        end
    end

    // fast temperature sequencer and channel flags
    always_comb begin
        seq_nxt      = seq_r;
        vres_nxt     = vres_r;
        vread_nxt    = vread_r;
        tvalid_nxt   = tvalid_r;
        vvalid_nxt   = vvalid_r;
        first_nxt    = first_r;
        chsw_nxt     = chsw_r;
        settle_nxt   = settle_r;
        temp_sel_nxt = o_temp_select;
        if (i_rd && i_addr == afr_pkg::VOLTAGE_RESULT_ADDR) begin
            vread_nxt  = 1'b1;
            vvalid_nxt = 1'b0;
            tvalid_nxt = 1'b0;
        end
        if (i_cur_done) begin
            first_nxt = 1'b0;
            unique case (seq_r)
                afr_pkg::AFR_VOLT: begin
                    if (fast_r && !first_r) begin
                        seq_nxt   = afr_pkg::AFR_ARMED;
                        vread_nxt = 1'b0;
                    end
                end
                afr_pkg::AFR_ARMED: begin
                    seq_nxt      = afr_pkg::AFR_TEMP;
                    temp_sel_nxt = 1'b1;
                end
                afr_pkg::AFR_TEMP: begin
                    seq_nxt      = afr_pkg::AFR_HOLD1;
                    temp_sel_nxt = 1'b0;
                end
                afr_pkg::AFR_HOLD1: seq_nxt = afr_pkg::AFR_HOLD2;
                afr_pkg::AFR_HOLD2: seq_nxt = afr_pkg::AFR_VOLT;
                default: seq_nxt = afr_pkg::AFR_VOLT;
            endcase
        end
        // config rewrite wins over a done in the same cycle
        if (cfg_wr) begin
            first_nxt    = 1'b1;
            seq_nxt      = afr_pkg::AFR_VOLT;
            temp_sel_nxt = 1'b0;
        end
        // slow path: manual channel switch settles over three conversions
        if (i_wr && i_addr == afr_pkg::MODE_REG_ADDR
            && i_wdata[0] != mode_r[0]) begin
            chsw_nxt   = 1'b1;
            settle_nxt = 2'h0;
        end else if (i_volt_done && chsw_r) begin
            settle_nxt = 2'(settle_r + 2'h1);
            if (2'(settle_r + 2'h1) == afr_pkg::SETTLE_CYCLES) begin
                chsw_nxt = 1'b0;
            end
        end
        if (i_volt_done && !(chsw_r && 2'(settle_r + 2'h1)
                             != afr_pkg::SETTLE_CYCLES)) begin
            if (seq_r == afr_pkg::AFR_TEMP) begin
                vres_nxt   = i_volt_data;
                tvalid_nxt = vread_r;
            end else if (seq_r == afr_pkg::AFR_VOLT
                         || seq_r == afr_pkg::AFR_ARMED) begin
                vres_nxt   = i_volt_data;
                vvalid_nxt = 1'b1;
            end
        end
    end

    // comparator, threshold counter and output controls
    always_comb begin
        cnt_nxt     = cnt_r;
        cmp_hit_nxt = 1'b0;
        cnt_hit_nxt = 1'b0;
        if (i_wr && i_addr == afr_pkg::COUNT_PRESET_ADDR) begin
            cnt_nxt = 16'h0000;
        end else if (i_cur_done && ccfg_r[afr_pkg::CMP_EN_BIT]) begin
            if (mag > thr_r) begin
                cmp_hit_nxt = 1'b1;
                if (ccfg_r[afr_pkg::CNT_EN_BIT]) begin
                    cnt_nxt = 16'(cnt_r + 16'h0001);
                    if (16'(cnt_r + 16'h0001) == preset_r) begin
                        cnt_hit_nxt = 1'b1;
                        cnt_nxt     = 16'h0000;
                    end
                end
            end
        end
        irq_nxt = cmp_hit_nxt || cnt_hit_nxt || (i_cur_done && !first_r);
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            refctl_r      <= afr_pkg::REFERENCE_CONTROL_RST;
            bufpd_r       <= afr_pkg::BUFFER_POWERDOWN_RST;
            flt_r         <= afr_pkg::FILTER_CONFIG_RST;
            pctl_r        <= afr_pkg::PRIMARY_CONTROL_RST;
            mode_r        <= 16'h0000;
            fast_r        <= 1'b0;
            vres_r        <= 20'h00000;
            thr_r         <= 20'h00000;
            ccfg_r        <= 16'h0000;
            preset_r      <= 16'h0000;
            cnt_r         <= 16'h0000;
            vread_r       <= 1'b0;
            tvalid_r      <= 1'b0;
            vvalid_r      <= 1'b0;
            first_r       <= 1'b1;
            chsw_r        <= 1'b0;
            settle_r      <= 2'h0;
            cmp_hit_r     <= 1'b0;
            cnt_hit_r     <= 1'b0;
            seq_r         <= afr_pkg::AFR_VOLT;
            o_rdata       <= 16'h0000;
            o_decim_factor <= 7'h00;
            o_avg_factor  <= 6'h00;
            o_temp_select <= 1'b0;
            o_diag_pos_en <= 1'b0;
            o_diag_neg_en <= 1'b0;
            o_scale_14_en <= 1'b1;
            o_scale_13_en <= 1'b1;
            o_ref_en      <= 1'b1;
            o_buf_en      <= 1'b0;
            o_ext_ref_sel <= 1'b1;
            o_irq         <= 1'b0;
        end else begin
            refctl_r      <= refctl_nxt;
            bufpd_r       <= bufpd_nxt;
            flt_r         <= flt_nxt;
            pctl_r        <= pctl_nxt;
            mode_r        <= mode_nxt;
            fast_r        <= fast_nxt;
            vres_r        <= vres_nxt;
            thr_r         <= thr_nxt;
            ccfg_r        <= ccfg_nxt;
            preset_r      <= preset_nxt;
            cnt_r         <= cnt_nxt;
            vread_r       <= vread_nxt;
            tvalid_r      <= tvalid_nxt;
            vvalid_r      <= vvalid_nxt;
            first_r       <= first_nxt;
            chsw_r        <= chsw_nxt;
            settle_r      <= settle_nxt;
            cmp_hit_r     <= cmp_hit_nxt;
            cnt_hit_r     <= cnt_hit_nxt;
            seq_r         <= seq_nxt;
            o_rdata       <= rdata_nxt;
            o_decim_factor <= decim_eff;
            o_avg_factor  <= avg_eff;
            o_temp_select <= temp_sel_nxt;
            o_diag_pos_en <= pctl_r[afr_pkg::DIAG_POS_BIT];
            o_diag_neg_en <= pctl_r[afr_pkg::DIAG_NEG_BIT];
            o_scale_14_en <= !pctl_r[afr_pkg::SCALE_HI_BIT];
            o_scale_13_en <= !pctl_r[afr_pkg::SCALE_LO_BIT];
            o_ref_en      <= refctl_r[afr_pkg::OWNER_SEL_BIT]
                             ? !refctl_r[afr_pkg::REF_PD_BIT]
                             : i_adc_ref_req;
            o_buf_en      <= !bufpd_r[afr_pkg::BUF_PD_BIT];
            o_ext_ref_sel <= bufpd_r[afr_pkg::BUF_PD_BIT];
            o_irq         <= irq_nxt;
        end
    end
endmodule

// ===== bench/afr_conv_model.sv
// model: modulator pair handing paired conversion results to the block
// assumes: conv task is called just after a rising clock edge
`timescale 1ns/10ps
module afr_conv_model (
    input  wire logic        i_core_clk,
    output logic             o_cur_done,
    output logic      [19:0] o_cur_data,
    output logic             o_volt_done,
    output logic      [19:0] o_volt_data
);
    initial begin
        o_cur_done  = 1'h0;
        o_volt_done = 1'h0;
        o_cur_data  = 20'h00000;
        o_volt_data = 20'h00000;
    end

    // one conversion after gap cycles, data lines not held afterwards
    task automatic conv(input logic [19:0] cur, input logic [19:0] volt,
                        input int gap);
        repeat (gap) @(posedge i_core_clk);
        o_cur_done  <= 1'h1;
        o_volt_done <= 1'h1;
        o_cur_data  <= cur;
        o_volt_data <= volt;
        @(posedge i_core_clk);
        o_cur_done  <= 1'h0;
        o_volt_done <= 1'h0;
        o_cur_data  <= ~cur;
        o_volt_data <= ~volt;
    endtask
endmodule

// ===== bench/afr_top_checker.sv
// checker: port relations of the converter control block
// assumes: bound to afr_top, one clock, sync active-high reset
`timescale 1ns/10ps
module afr_top_checker (
    input wire logic        i_core_clk,
    input wire logic        i_sys_rst,
    input wire logic [31:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_cur_done,
    input wire logic        i_adc_ref_req,
    input wire logic [6:0]  o_decim_factor,
    input wire logic [5:0]  o_avg_factor,
    input wire logic        o_temp_select,
    input wire logic        o_diag_pos_en,
    input wire logic        o_diag_neg_en,
    input wire logic        o_scale_14_en,
    input wire logic        o_scale_13_en,
    input wire logic        o_ref_en,
    input wire logic        o_buf_en,
    input wire logic        o_ext_ref_sel,
    input wire logic        o_irq
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_sys_rst);

    // shadows: reference, buffer, filter, primary control
    logic [15:0] sh_r   [4];
    logic [15:0] sh_nxt [4];

    always_comb begin
        sh_nxt = sh_r;
        if (i_wr) begin
            case (i_addr)
                afr_pkg::REFERENCE_CONTROL_ADDR: sh_nxt[0] = i_wdata;
                afr_pkg::BUFFER_POWERDOWN_ADDR:  sh_nxt[1] = i_wdata;
                afr_pkg::FILTER_CONFIG_ADDR:     sh_nxt[2] = i_wdata;
                afr_pkg::PRIMARY_CONTROL_ADDR:   sh_nxt[3] = i_wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            sh_r[0] <= afr_pkg::REFERENCE_CONTROL_RST;
            sh_r[1] <= afr_pkg::BUFFER_POWERDOWN_RST;
            sh_r[2] <= afr_pkg::FILTER_CONFIG_RST;
            sh_r[3] <= afr_pkg::PRIMARY_CONTROL_RST;
        end else begin
            sh_r <= sh_nxt;
        end
    end

    avg_forced_a: assert property (
        $stable(sh_r[2]) |->
        o_avg_factor == (sh_r[2][14] ? 6'h00 : sh_r[2][13:8]))
        else $error("averaging factor wrong for filter mode");
    decim_clamp_a: assert property (
        $stable(sh_r[2]) && sh_r[2][14] |-> o_decim_factor ==
        ((sh_r[2][6:0] > 7'h0E) ? afr_pkg::DECIM_SINC4_MAX : sh_r[2][6:0]))
        else $error("decimation factor not clamped");
    diag_src_a: assert property (
        $stable(sh_r[3]) |->
        {o_diag_neg_en, o_diag_pos_en} == sh_r[3][13:12])
        else $error("diagnostic sources differ from control bits");
    pga_scale_a: assert property (
        $stable(sh_r[3]) |->
        {o_scale_14_en, o_scale_13_en} == ~sh_r[3][11:10])
        else $error("scaling enables differ from field");
    ref_user_a: assert property (
        $stable(sh_r[0]) && sh_r[0][1] |-> o_ref_en == !sh_r[0][0])
        else $error("user reference enable wrong");
    ref_auto_a: assert property (
        $stable(sh_r[0]) && !sh_r[0][1] |=>
        o_ref_en == $past(i_adc_ref_req))
        else $error("automatic reference does not follow converter");
    buf_pd_a: assert property (
        $stable(sh_r[1]) |->
        o_buf_en == !sh_r[1][0] && o_ext_ref_sel == sh_r[1][0])
        else $error("buffer or external routing wrong");
    irq_cause_a: assert property (
        o_irq |-> $past(i_cur_done))
        else $error("interrupt without current result");

    cover property (sh_r[2][14] && o_decim_factor == 7'h0E);
    cover property (o_irq);
    cover property ($rose(o_temp_select));
endmodule

bind afr_top afr_top_checker i_afr_top_checker (.*);

// ===== bench/afr_top_test.sv
// testbench: converter control block with modulator model
// assumes: afr_top and afr_pkg compiled first
`timescale 1ns/10ps
module afr_top_test;
    logic        i_core_clk = 1'h0;
    logic        i_sys_rst = 1'h1;
    logic [31:0] i_addr = 32'h0000_0000;
    logic [15:0] i_wdata = 16'h0000;
    logic        i_wr = 1'h0;
    logic        i_rd = 1'h0;
    logic        i_adc_ref_req = 1'h0;
    logic        i_cur_done;
    logic [19:0] i_cur_data;
    logic        i_volt_done;
    logic [19:0] i_volt_data;
    logic [15:0] o_rdata;
    logic [6:0]  o_decim_factor;
    logic [5:0]  o_avg_factor;
    logic        o_temp_select;
    logic        o_diag_pos_en;
    logic        o_diag_neg_en;
    logic        o_scale_14_en;
    logic        o_scale_13_en;
    logic        o_ref_en;
    logic        o_buf_en;
    logic        o_ext_ref_sel;
    logic        o_irq;
    int          mismatches = 0;
    int          checks = 0;
    logic [15:0] s;

    afr_top i_afr_top (.*);
    afr_conv_model i_afr_conv_model (
        .i_core_clk  (i_core_clk),
        .o_cur_done  (i_cur_done),
        .o_cur_data  (i_cur_data),
        .o_volt_done (i_volt_done),
        .o_volt_data (i_volt_data)
    );

    always #5 i_core_clk = ~i_core_clk;

    task automatic cyc(input int n);
        repeat (n) @(posedge i_core_clk);
    endtask
    task automatic chk(input logic [31:0] seen, exp, input string what);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t %s", $time, what);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        i_wr <= 1'h1;
        i_addr <= a;
        i_wdata <= d;
        cyc(1);
        i_wr <= 1'h0;
        cyc(1);
    endtask
    task automatic rd(input logic [31:0] a, output logic [15:0] d);
        i_rd <= 1'h1;
        i_addr <= a;
        cyc(1);
        i_rd <= 1'h0;
        cyc(1);
        d = o_rdata;
    endtask
    task automatic cv(input logic [19:0] cur, input int gap = 4);
        i_afr_conv_model.conv(cur, 20'h12345, gap);
    endtask

    task automatic t_reset();
        rd(afr_pkg::REFERENCE_CONTROL_ADDR, s);
        chk(s, 16'h0002, "ref ctl reset");
        rd(afr_pkg::BUFFER_POWERDOWN_ADDR, s);
        chk(s, 16'h0001, "buffer reset");
        rd(afr_pkg::FILTER_CONFIG_ADDR, s);
        chk(s, 16'h0007, "filter reset");
        wr(32'h4000_8800, 16'hFFFF);
        rd(32'h4000_8800, s);
        chk(s, 16'h0000, "unmapped read");
        chk({o_ref_en, o_buf_en, o_ext_ref_sel}, 3'h5, "ref outs");
    endtask

    task automatic t_filter();
        logic [15:0] w [4];
        logic [6:0]  e;
        w = '{16'h4F0F, 16'h450E, 16'h3F7F, 16'h4001};
        foreach (w[k]) begin
            wr(afr_pkg::FILTER_CONFIG_ADDR, w[k]);
            cyc(3);
            chk(o_avg_factor, w[k][14] ? 6'h00 : w[k][13:8], "avg");
            e = (w[k][14] && w[k][6:0] > 7'h0E) ? 7'h0E : w[k][6:0];
            chk(o_decim_factor, e, "decim");
        end
    endtask

    task automatic t_primary();
        for (int k = 0; k < 4; k++) begin
            wr(afr_pkg::PRIMARY_CONTROL_ADDR,
               16'((k << 12) | ((3 - k) << 10)));
            cyc(3);
            chk({o_diag_neg_en, o_diag_pos_en}, k, "diag");
            chk({o_scale_14_en, o_scale_13_en}, k, "scale");
        end
    endtask

    task automatic t_ref();
        wr(afr_pkg::REFERENCE_CONTROL_ADDR, 16'h0003);
        cyc(3);
        chk(o_ref_en, 1'h0, "ref down");
        wr(afr_pkg::REFERENCE_CONTROL_ADDR, 16'h0001);
        i_adc_ref_req <= 1'h1;
        cyc(3);
        chk(o_ref_en, 1'h1, "auto ref on");
        i_adc_ref_req <= 1'h0;
        cyc(3);
        chk(o_ref_en, 1'h0, "auto ref off");
        wr(afr_pkg::BUFFER_POWERDOWN_ADDR, 16'h0000);
        cyc(3);
        chk({o_buf_en, o_ext_ref_sel}, 2'h2, "buffer on");
        wr(afr_pkg::BUFFER_POWERDOWN_ADDR, 16'h0001);
        wr(afr_pkg::REFERENCE_CONTROL_ADDR, 16'h0002);
        cyc(3);
        chk({o_ref_en, o_buf_en, o_ext_ref_sel}, 3'h5, "ext ref");
    endtask

    task automatic t_cmp();
        wr(afr_pkg::THRESHOLD_ADDR, 16'h0010);
        wr(afr_pkg::COMPARE_CONFIG_ADDR, 16'h0003);
        wr(afr_pkg::COUNT_PRESET_ADDR, 16'h0003);
        cv(20'h00001);
        cv(20'h40000);
        cyc(1);
        chk(o_irq, 1'h1, "irq set");
        cyc(1);
        chk(o_irq, 1'h0, "irq pulse");
        cv(20'h40000);
        rd(afr_pkg::STATUS_ADDR, s);
        chk(s[6:5], 2'h1, "over threshold");
        cv(20'hFFFFE);
        rd(afr_pkg::STATUS_ADDR, s);
        chk(s[5], 1'h0, "below threshold");
        cv(20'hC0000);
        rd(afr_pkg::STATUS_ADDR, s);
        chk(s[6:5], 2'h3, "count reached");
    endtask

    task automatic t_acc();
        wr(afr_pkg::ACCUM_LO_ADDR, 16'h0000);
        cv(20'h40000, 1);
        cv(20'h40000, 1);
        cv(20'hFFFFF, 6);
        cyc(2);
        rd(afr_pkg::ACCUM_HI_ADDR, s);
        chk(s, 16'h0007, "acc high");
        rd(afr_pkg::ACCUM_LO_ADDR, s);
        chk(s, 16'hFFFF, "acc low");
    endtask

    task automatic t_fast();
        wr(afr_pkg::FILTER_CONFIG_ADDR, 16'h0007);
        cv(20'h00002);
        wr(afr_pkg::FAST_TEMP_ADDR, 16'h0001);
        cv(20'h00002);
        rd(afr_pkg::VOLTAGE_RESULT_ADDR, s);
        chk(o_temp_select, 1'h0, "armed only");
        cv(20'h00002);
        cyc(2);
        chk(o_temp_select, 1'h1, "temp routed");
        cv(20'h00002);
        cyc(2);
        chk(o_temp_select, 1'h0, "temp done");
        rd(afr_pkg::STATUS_ADDR, s);
        chk(s[1], 1'h1, "temp valid");
        rd(afr_pkg::VOLTAGE_RESULT_ADDR, s);
        wr(afr_pkg::FAST_TEMP_ADDR, 16'h0000);
        cv(20'h00002);
        cv(20'h00002);
        rd(afr_pkg::STATUS_ADDR, s);
        chk(s[0], 1'h0, "no voltage in holds");
        cv(20'h00002);
        rd(afr_pkg::STATUS_ADDR, s);
        chk(s[0], 1'h1, "voltage resumes");
        wr(afr_pkg::MODE_REG_ADDR, 16'h0001);
        rd(afr_pkg::VOLTAGE_RESULT_ADDR, s);
        cv(20'h00002);
        cv(20'h00002);
        rd(afr_pkg::STATUS_ADDR, s);
        chk(s[0], 1'h0, "switch not settled");
        cv(20'h00002);
        rd(afr_pkg::STATUS_ADDR, s);
        chk(s[0], 1'h1, "switch settled");
    endtask

    task automatic summarize();
        if (mismatches == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        cyc(5);
        i_sys_rst <= 1'h0;
        t_reset();
        t_filter();
        t_primary();
        t_ref();
        t_cmp();
        t_acc();
        t_fast();
        summarize();
    end

    initial begin
        #100000;
        mismatches++;
        summarize();
    end
endmodule
